//--- tfa_ctrl.sv
/*
 T1 framing mode, transmit alarm and data link control with the transmit
 overhead inserter. Assumes the processor port is synchronous to core_clk,
 one line bit per clock, and same-clock HDLC and receive framer logic.
*/
`timescale 1ns/1ps
`include "tfa_defs.svh"
module tfa_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cpu_cs,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [4:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic data_link_in,
    input wire logic hdlc_fdl_tx_bit,
    input wire logic hdlc_chan_tx_bit,
    input wire logic backplane_data_in,
    input wire logic backplane_sync_bit,
    input wire tfa_pkg::tfa_rx_fbit_s rx_fbit,
    input wire logic rx_multiframe_sync,
    output logic line_tx_positive,
    output logic line_tx_negative,
    output tfa_pkg::tfa_pos_s tx_pos,
    output logic data_link_req,
    output logic hdlc_fdl_req,
    output logic hdlc_chan_req,
    output logic fs_error_pulse,
    output logic reframe_start,
    output logic multiframe_resync_start,
    output logic signalling_freeze,
    output logic secondary_yellow_detect,
    output tfa_pkg::tfa_mode_s mode
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [5:0] crc6_step(input logic [5:0] c,
                                             input logic d);
        logic fb;
        fb = c[5] ^ d;
        crc6_step = {c[4:0], 1'b0} ^ (fb ? `TFA_CRC_POLY : 6'h00);
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] framing_mode_select;
    logic [7:0] transmit_alarm_control;
    logic [7:0] data_link_control;
    logic [7:0] tx_bit_message;
    logic wr_en;
    logic dl_meta;
    logic dl_sync;
    assign wr_en = cpu_cs & cpu_wr;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            framing_mode_select <= `TFA_RST_FMS;
            transmit_alarm_control <= `TFA_RST_TAC;
            data_link_control <= `TFA_RST_DLC;
            tx_bit_message <= `TFA_RST_BOM;
        end else if (wr_en) begin
            // Written bits steer the inserter on the next slot
            unique case (cpu_addr)
                `TFA_ADDR_FMS: framing_mode_select <= cpu_wdata;
                `TFA_ADDR_TAC: transmit_alarm_control <= cpu_wdata;
                `TFA_ADDR_DLC: data_link_control <= cpu_wdata;
                `TFA_ADDR_BOM: tx_bit_message <= cpu_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_cs & cpu_rd) begin
            unique case (cpu_addr)
                `TFA_ADDR_FMS: cpu_rdata <= framing_mode_select;
                `TFA_ADDR_TAC: cpu_rdata <= transmit_alarm_control;
                `TFA_ADDR_DLC: cpu_rdata <= data_link_control;
                `TFA_ADDR_BOM: cpu_rdata <= tx_bit_message;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    // Data link pin is asynchronous to the core clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dl_meta <= 1'b0;
            dl_sync <= 1'b0;
        end else begin
            dl_meta <= data_link_in;
            dl_sync <= dl_meta;
        end
    end

    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    logic esf;
    logic fs_inc;
    logic sec_sel;
    logic ovr;
    logic japan_crc_sbits;
    logic transparent;
    assign esf = framing_mode_select[`TFA_B_ESF];
    assign fs_inc = framing_mode_select[`TFA_B_FSI];
    assign sec_sel = transmit_alarm_control[`TFA_B_SECSEL];
    assign ovr = transmit_alarm_control[`TFA_B_OVR];
    assign japan_crc_sbits = data_link_control[`TFA_B_JTS];
    assign transparent = data_link_control[`TFA_B_TRANSPARENT_MODE];
    assign mode = '{esf_mode: esf, transparent: transparent,
                    hdlc_chan_rate: data_link_control[`TFA_B_H1R]};

    // ----------------------------------------
    // Frame position
    // ----------------------------------------
    logic [7:0] slot;
    logic [4:0] frame;
    logic [7:0] slot_m1;
    logic fslot;
    logic [4:0] chan;
    logic [2:0] bitn;
    logic [4:0] frame_last;
    logic frame_end;
    logic mf_end;
    assign slot_m1 = slot - 8'd1;
    assign fslot = (slot == 8'd0);
    assign chan = slot_m1[7:3];
    assign bitn = slot_m1[2:0];
    assign frame_last = esf ? `TFA_ESF_LAST : `TFA_D4_LAST;
    assign frame_end = (slot == `TFA_SLOT_LAST);
    assign mf_end = frame_end & (frame >= frame_last);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slot <= 8'd0;
            frame <= 5'd0;
        end else begin
            slot <= frame_end ? 8'd0 : slot + 8'd1;
            if (frame_end) begin
                // A one from channel 31 bit 0 marks the last frame
                if (data_link_control[`TFA_B_TX_MULTIFRAME_ALIGN] & backplane_sync_bit)
                    frame <= 5'd0;
                else if (frame >= frame_last)
                    frame <= 5'd0;
                else
                    frame <= frame + 5'd1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_pos <= '0;
        end else begin
            tx_pos <= '{frame: frame, fslot: fslot, chan: chan, bitn: bitn};
        end
    end

    // ----------------------------------------
    // Overhead bit
    // ----------------------------------------
    logic [3:0] fdl_cnt;
    logic [5:0] crc;
    logic [5:0] crc_tx;
    logic [2:0] fidx;
    logic esf_fdl;
    logic fdl_bit;
    logic f_bit;
    assign fidx = frame[4:2];
    assign esf_fdl = esf & fslot & ~frame[0];
    assign data_link_req = fslot & data_link_control[`TFA_B_EDL] &
                           (esf ? ~frame[0] : frame[0]);
    assign hdlc_fdl_req = esf_fdl & data_link_control[`TFA_B_H0] &
                          ~transmit_alarm_control[`TFA_B_ESF_YELLOW_SEND] &
                          ~data_link_control[`TFA_B_BOM];

    // FDL source priority: yellow, message, HDLC, pin, idle ones
    always_comb begin
        fdl_bit = 1'b1;
        if (transmit_alarm_control[`TFA_B_ESF_YELLOW_SEND])
            fdl_bit = japan_crc_sbits | (fdl_cnt < `TFA_HALF_PAT);
        else if (data_link_control[`TFA_B_BOM])
            fdl_bit = (fdl_cnt < `TFA_HALF_PAT) ?
                      tx_bit_message[3'd7 - fdl_cnt[2:0]] : 1'b1;
        else if (data_link_control[`TFA_B_H0])
            fdl_bit = hdlc_fdl_tx_bit;
        else if (data_link_control[`TFA_B_EDL])
            fdl_bit = dl_sync;
    end

    always_comb begin
        f_bit = 1'b0;
        if (esf) begin
            unique case (frame[1:0])
                2'd0, 2'd2: f_bit = fdl_bit;
                2'd1: f_bit = crc_tx[3'd5 - fidx];
                2'd3: f_bit = 1'(`TFA_FPS_PAT >> (3'd5 - fidx));
            endcase
        end else if (~frame[0]) begin
            f_bit = ~frame[1];
        end else if (frame == `TFA_D4_LAST &
                     transmit_alarm_control[`TFA_B_TXSEC]) begin
            f_bit = 1'b1;
        end else if (data_link_control[`TFA_B_EDL]) begin
            f_bit = dl_sync;
        end else begin
            f_bit = 1'(`TFA_FS_PAT >> (3'd5 - frame[3:1]));
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fdl_cnt <= 4'd0;
        end else if (esf_fdl) begin
            fdl_cnt <= fdl_cnt + 4'd1;
        end
    end

    // ----------------------------------------
    // Payload and alarm patterns
    // ----------------------------------------
    logic payload_bit;
    logic pat_bit;
    logic tx_bit;
    logic [2:0] pat_cnt;
    logic [2:0] pat_last;
    logic h1_slot;
    tfa_pkg::tfa_src_e src;
    assign h1_slot = data_link_control[`TFA_B_H1] & ~fslot &
                     (chan == `TFA_CHAN_LAST);
    // 56 Kb/s keeps the last bit high so stuffing never hits data
    assign hdlc_chan_req = h1_slot & (data_link_control[`TFA_B_H1R] |
                           (bitn != `TFA_BIT_LAST));

    always_comb begin
        payload_bit = backplane_data_in;
        if (h1_slot)
            payload_bit = hdlc_chan_req ? hdlc_chan_tx_bit : 1'b1;
        if (transmit_alarm_control[`TFA_B_D4_YELLOW_SEND] & bitn == `TFA_YEL_BIT)
            payload_bit = 1'b0;
    end

    always_comb begin
        if (~transmit_alarm_control[`TFA_B_AON])
            src = tfa_pkg::TFA_SRC_ONES;
        else if (transmit_alarm_control[`TFA_B_LUP])
            src = tfa_pkg::TFA_SRC_LUP;
        else if (transmit_alarm_control[`TFA_B_LDN])
            src = tfa_pkg::TFA_SRC_LDN;
        else
            src = tfa_pkg::TFA_SRC_NORMAL;
    end

    assign pat_last = (src == tfa_pkg::TFA_SRC_LUP) ? `TFA_LUP_LAST :
                      `TFA_LDN_LAST;

    always_comb begin
        pat_bit = 1'b1;
        tx_bit = 1'b1;
        unique case (src)
            tfa_pkg::TFA_SRC_NORMAL: begin
                if (transparent)
                    tx_bit = backplane_data_in;
                else
                    tx_bit = fslot ? f_bit : payload_bit;
            end
            tfa_pkg::TFA_SRC_ONES: begin
                tx_bit = (ovr & fslot) ? f_bit : 1'b1;
            end
            tfa_pkg::TFA_SRC_LUP, tfa_pkg::TFA_SRC_LDN: begin
                pat_bit = (pat_cnt == pat_last);
                tx_bit = (ovr & fslot) ? f_bit : pat_bit;
            end
        endcase
    end

    // Pattern phase holds still across overlaid framing bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pat_cnt <= 3'd0;
        end else if (src == tfa_pkg::TFA_SRC_NORMAL |
                     src == tfa_pkg::TFA_SRC_ONES) begin
            pat_cnt <= 3'd0;
        end else if (~(ovr & fslot)) begin
            pat_cnt <= (pat_cnt >= pat_last) ? 3'd0 : pat_cnt + 3'd1;
        end
    end

    // ----------------------------------------
    // CRC-6 over each superframe
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crc <= 6'h00;
            crc_tx <= 6'h00;
        end else if (mf_end) begin
            crc_tx <= crc6_step(crc, tx_bit);
            crc <= 6'h00;
        end else if (~fslot | japan_crc_sbits) begin
            crc <= crc6_step(crc, tx_bit);
        end
    end

    // ----------------------------------------
    // Line output, alternate mark inversion
    // ----------------------------------------
    logic mark_neg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_tx_positive <= 1'b0;
            line_tx_negative <= 1'b0;
            mark_neg <= 1'b0;
        end else begin
            line_tx_positive <= tx_bit & ~mark_neg;
            line_tx_negative <= tx_bit & mark_neg;
            mark_neg <= mark_neg ^ tx_bit;
        end
    end

    // ----------------------------------------
    // Receive framing policy
    // ----------------------------------------
    logic fs_frame12;
    assign fs_frame12 = rx_fbit.frame == `TFA_D4_LAST;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fs_error_pulse <= 1'b0;
            secondary_yellow_detect <= 1'b0;
        end else begin
            fs_error_pulse <= rx_fbit.valid & rx_fbit.is_fs & ~esf & fs_inc &
                              (rx_fbit.received != rx_fbit.expected) &
                              ~(fs_frame12 & sec_sel);
            if (~sec_sel)
                secondary_yellow_detect <= 1'b0;
            else if (rx_fbit.valid & rx_fbit.is_fs & fs_frame12)
                secondary_yellow_detect <= rx_fbit.received;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reframe_start <= 1'b0;
            multiframe_resync_start <= 1'b0;
            signalling_freeze <= 1'b0;
        end else begin
            reframe_start <= wr_en & (cpu_addr == `TFA_ADDR_FMS) &
                             cpu_wdata[`TFA_B_FORCE_REFRAME];
            multiframe_resync_start <= wr_en & ~cpu_wdata[`TFA_B_ESF] &
                                       (cpu_addr == `TFA_ADDR_FMS) &
                                       cpu_wdata[`TFA_B_FORCE_MULTIFRAME_RESYNC];
            // New resync wins over a sync report in the same cycle
            if (multiframe_resync_start)
                signalling_freeze <= 1'b1;
            else if (rx_multiframe_sync)
                signalling_freeze <= 1'b0;
        end
    end
endmodule // tfa_ctrl

//--- tfa_ctrl_assertions.sv
/*
 Port checker of the T1 framing, alarm and data link control block.
 Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/1ps
module tfa_ctrl_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cpu_cs,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [4:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire tfa_pkg::tfa_rx_fbit_s rx_fbit,
    input wire logic line_tx_positive,
    input wire logic line_tx_negative,
    input wire tfa_pkg::tfa_pos_s tx_pos,
    input wire logic data_link_req,
    input wire logic hdlc_chan_req,
    input wire logic fs_error_pulse,
    input wire logic reframe_start,
    input wire logic multiframe_resync_start,
    input wire logic signalling_freeze,
    input wire logic secondary_yellow_detect,
    input wire tfa_pkg::tfa_mode_s mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Shadow registers
    // ----------------------------------------
    logic [7:0] fms, tac, dlc, bom, rexp;
    logic wr10, fs_hit, mark;
    assign wr10 = cpu_cs && cpu_wr && cpu_addr == 5'h10;
    assign mark = line_tx_positive || line_tx_negative;
    // Shadows follow writes only, so a stuck design register shows up
    assign fs_hit = rx_fbit.valid && rx_fbit.is_fs && !fms[7] && fms[2]
        && rx_fbit.received != rx_fbit.expected
        && !(rx_fbit.frame == 5'd11 && tac[1]);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fms <= 8'h00;
            tac <= 8'h10;
            dlc <= 8'h00;
            bom <= 8'h00;
        end else if (cpu_cs && cpu_wr) begin
            if (cpu_addr == 5'h10) fms <= cpu_wdata;
            if (cpu_addr == 5'h11) tac <= cpu_wdata;
            if (cpu_addr == 5'h12) dlc <= cpu_wdata;
            if (cpu_addr == 5'h13) bom <= cpu_wdata;
        end
    end
    always_comb begin
        case (cpu_addr)
            5'h10: rexp = fms;
            5'h11: rexp = tac;
            5'h12: rexp = dlc;
            5'h13: rexp = bom;
            default: rexp = 8'h00;
        endcase
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    reframe_pulse_a: assert property (
        reframe_start == $past(wr10 && cpu_wdata[1]))
        else $error("reframe pulse wrong");
    mf_resync_a: assert property (
        wr10 && cpu_wdata[0] && !cpu_wdata[7]
        |=> multiframe_resync_start ##1 signalling_freeze)
        else $error("multiframe resync missing");
    fs_error_a: assert property (
        fs_error_pulse == $past(fs_hit))
        else $error("fs error pulse wrong");
    sec_yel_clear_a: assert property (
        !tac[1] |=> !secondary_yellow_detect)
        else $error("secondary yellow not cleared");
    sec_yel_load_a: assert property (
        rx_fbit.valid && rx_fbit.is_fs && rx_fbit.frame == 5'd11 && tac[1]
        |=> secondary_yellow_detect == $past(rx_fbit.received))
        else $error("secondary yellow not loaded");
    reg_read_a: assert property (
        cpu_cs && cpu_rd |=> cpu_rdata == $past(rexp))
        else $error("read data wrong");
    mode_out_a: assert property (
        mode == {fms[7], dlc[2], dlc[0]})
        else $error("mode output wrong");
    ami_mark_a: assert property (!(line_tx_positive && line_tx_negative))
        else $error("both line outputs high");
    all_ones_a: assert property (
        !tac[4] && $past(!tac[4]) && !tx_pos.fslot |-> mark)
        else $error("all ones not sent");
    d4_yellow_a: assert property (
        tac == 8'h30 && $past(tac) == 8'h30 && !fms[7] && dlc == 8'h00
        && !tx_pos.fslot && tx_pos.bitn == 3'd1 |-> !mark)
        else $error("yellow bit not forced low");
    chan_req_a: assert property (hdlc_chan_req |-> dlc[4])
        else $error("channel request without enable");
    link_req_a: assert property (data_link_req |-> dlc[7])
        else $error("data link request without enable");
endmodule // tfa_ctrl_assertions

//--- tfa_ctrl_tb_top.sv
/*
 Self-checking bench of the control block with the line model.
 Assumes the package, the checker and the design are compiled first.
*/
`timescale 1ns/1ps
module tfa_ctrl_tb_top;
    logic core_clk, rst, cpu_cs, cpu_wr, cpu_rd, rx_multiframe_sync;
    logic [4:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata;
    logic data_link_in, hdlc_fdl_tx_bit, hdlc_chan_tx_bit;
    logic backplane_data_in, backplane_sync_bit, line_tx_positive;
    logic line_tx_negative, data_link_req, hdlc_fdl_req, hdlc_chan_req;
    logic fs_error_pulse, reframe_start, multiframe_resync_start;
    logic signalling_freeze, secondary_yellow_detect, ami_fault;
    tfa_pkg::tfa_rx_fbit_s rx_fbit;
    tfa_pkg::tfa_pos_s tx_pos;
    tfa_pkg::tfa_mode_s mode;
    int error_cnt, total_checks, cycles;
    tfa_ctrl dut_u (.*);
    tfa_line_model line_u (.*);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [8:0] seen,
        input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cpu_cs = 1'b1;
        cpu_wr = 1'b1;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge core_clk);
        cpu_cs = 1'b0;
        cpu_wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        cpu_cs = 1'b1;
        cpu_rd = 1'b1;
        cpu_addr = a;
        @(negedge core_clk);
        cpu_cs = 1'b0;
        cpu_rd = 1'b0;
        check("cpu_rdata", cpu_rdata, exp);
    endtask
    // Windows of whole frames or whole loop pattern periods, so the count does not hang on phase
    task automatic line_case(input logic [7:0] t, d, input int n,
        input logic p, input logic [8:0] eo, eh);
        logic [8:0] c, h;
        reg_wr(5'h11, t);
        reg_wr(5'h12, d);
        repeat (3) @(negedge core_clk);
        c = 9'h000;
        h = 9'h000;
        repeat (n) begin
            @(negedge core_clk);
            if ((line_tx_positive || line_tx_negative)
                && !(p && tx_pos.fslot)) c++;
            if (hdlc_chan_req || data_link_req) h++;
        end
        check("line ones", c, eo);
        check("chan requests", h, eh);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {cpu_cs, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
        {data_link_in, hdlc_fdl_tx_bit, hdlc_chan_tx_bit} = 3'b111;
        {backplane_data_in, backplane_sync_bit} = 2'b10;
        rst = 1'b1;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        reg_rd(5'h10, 8'h00);
        reg_rd(5'h11, 8'h10);
        reg_rd(5'h12, 8'h00);
        reg_wr(5'h14, 8'hff);
        reg_rd(5'h14, 8'h00);
        reg_wr(5'h12, 8'ha5);
        check("mode", mode, 8'h03);
        reg_rd(5'h12, 8'ha5);
        reg_wr(5'h12, 8'h00);
        reg_wr(5'h10, 8'h02);
        check("reframe_start", reframe_start, 8'h01);
        reg_wr(5'h10, 8'h01);
        check("mf resync", multiframe_resync_start, 8'h01);
        @(negedge core_clk);
        check("freeze", signalling_freeze, 8'h01);
        line_u.sync_pulse();
        check("freeze", signalling_freeze, 8'h00);
        reg_wr(5'h10, 8'h81);
        check("mf resync", multiframe_resync_start, 8'h00);
        check("mode", mode, 8'h04);
        reg_wr(5'h10, 8'h04);
        line_u.send_fbit(5'd3, 1'b1, 1'b0);
        check("fs error", fs_error_pulse, 8'h01);
        line_u.send_fbit(5'd3, 1'b1, 1'b1);
        check("fs error", fs_error_pulse, 8'h00);
        line_u.send_fbit(5'd11, 1'b1, 1'b0);
        check("fs error", fs_error_pulse, 8'h01);
        reg_wr(5'h11, 8'h12);
        line_u.send_fbit(5'd11, 1'b1, 1'b0);
        check("fs error", fs_error_pulse, 8'h00);
        check("sec yellow", secondary_yellow_detect, 8'h01);
        reg_wr(5'h11, 8'h10);
        @(negedge core_clk);
        check("sec yellow", secondary_yellow_detect, 8'h00);
        reg_wr(5'h10, 8'h84);
        line_u.send_fbit(5'd3, 1'b1, 1'b0);
        check("fs error", fs_error_pulse, 8'h00);
        reg_wr(5'h10, 8'h00);
        line_u.send_fbit(5'd3, 1'b1, 1'b0);
        check("fs error", fs_error_pulse, 8'h00);
        line_case(8'h10, 8'h00, 193, 1'b1, 8'd192, 8'd0);
        line_case(8'h30, 8'h00, 193, 1'b1, 8'd168, 8'd0);
        line_case(8'h00, 8'h00, 193, 1'b0, 8'd193, 8'd0);
        line_case(8'h01, 8'h00, 193, 1'b1, 8'd192, 8'd0);
        line_case(8'h18, 8'h00, 50, 1'b0, 8'd10, 8'd0);
        line_case(8'h14, 8'h00, 48, 1'b0, 8'd16, 8'd0);
        line_case(8'h10, 8'h04, 193, 1'b0, 8'd193, 8'd0);
        line_case(8'h10, 8'h11, 193, 1'b1, 8'd192, 8'd8);
        line_case(8'h10, 8'h10, 193, 1'b1, 8'd192, 8'd7);
        line_case(8'h10, 8'h80, 386, 1'b1, 9'd384, 9'd1);
        check("ami fault", ami_fault, 8'h00);
        end_of_test();
    end
endmodule // tfa_ctrl_tb_top
bind tfa_ctrl tfa_ctrl_assertions chk_u (.*);

//--- tfa_defs.svh
/*
 Constants of the T1 framing, alarm and data link control block.
 Assumes inclusion by bare name from the design module.
*/
// What this block does
// - D4 with Fs-include set counts errored Fs bits as framing errors
// - Frame 12 Fs bit counts only while secondary-yellow select is low
// - Writing reframe bit one starts an automatic frame resynchronisation
// - D4 multiframe reframe freezes signalling until multiframe sync returns
// - ESF yellow sends eight ones eight zeros, or sixteen ones, on FDL
// - D4 transmit secondary yellow forces S bit of frame 12 to one
// - D4 yellow forces bit 2 of every transmitted channel to zero
// - Transmit-all-ones control low sends all ones, framed per override
// - Loop-up control sends repeating 00001, framed per override
// - Loop-down control sends repeating 001, framed per override
// - Secondary yellow select drops frame 12 Fs; received one sets detect
// - Overhead override overlays framing bits on ones and loop patterns
// - Data link enable puts pin stream into FDL (ESF) or Fs (D4)
// - Bit message enable sends message word on ESF FDL
// - First HDLC enable routes its transmitter into ESF FDL bits
// - Second HDLC enable routes its transmitter onto channel 24
// - Transmit sync aligns multiframe to backplane channel 31 bit 0
// - Transparent mode passes unframed data both directions
// - Japanese sync control includes S bits in CRC-6
// - Second HDLC rate: high 64 Kb/s, low 56 Kb/s on channel 24
// - ESF select enables 24-frame superframe, clear means D4
`ifndef TFA_DEFS_SVH
`define TFA_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define TFA_ADDR_FMS 5'h10
`define TFA_ADDR_TAC 5'h11
`define TFA_ADDR_DLC 5'h12
`define TFA_ADDR_BOM 5'h13
`define TFA_RST_FMS 8'h00
`define TFA_RST_TAC 8'h10
`define TFA_RST_DLC 8'h00
`define TFA_RST_BOM 8'h00
// ----------------------------------------
// Bit positions
// ----------------------------------------
`define TFA_B_ESF 7
`define TFA_B_FSI 2
`define TFA_B_FORCE_REFRAME 1
`define TFA_B_FORCE_MULTIFRAME_RESYNC 0
`define TFA_B_ESF_YELLOW_SEND 7
`define TFA_B_TXSEC 6
`define TFA_B_D4_YELLOW_SEND 5
`define TFA_B_AON 4
`define TFA_B_LUP 3
`define TFA_B_LDN 2
`define TFA_B_SECSEL 1
`define TFA_B_OVR 0
`define TFA_B_EDL 7
`define TFA_B_BOM 6
`define TFA_B_H0 5
`define TFA_B_H1 4
`define TFA_B_TX_MULTIFRAME_ALIGN 3
`define TFA_B_TRANSPARENT_MODE 2
`define TFA_B_JTS 1
`define TFA_B_H1R 0
// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define TFA_SLOT_LAST 8'd192
`define TFA_CHAN_LAST 5'd23
`define TFA_BIT_LAST 3'd7
`define TFA_YEL_BIT 3'd1
`define TFA_D4_LAST 5'd11
`define TFA_ESF_LAST 5'd23
`define TFA_LUP_LAST 3'd4
`define TFA_LDN_LAST 3'd2
`define TFA_HALF_PAT 4'd8
`define TFA_CRC_POLY 6'h03
`define TFA_FPS_PAT 6'b001011
`define TFA_FS_PAT 6'b001110
`endif

//--- tfa_line_model.sv
/*
 Remote terminal side of the T1 line: checks AMI marks and feeds the
 receive framing bit and multiframe sync inputs. Assumes falling-edge drive.
*/
`timescale 1ns/1ps
module tfa_line_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic line_tx_positive,
    input wire logic line_tx_negative,
    output tfa_pkg::tfa_rx_fbit_s rx_fbit,
    output logic rx_multiframe_sync,
    output logic ami_fault
);
    logic last_pol, marked;
    initial begin
        rx_fbit = '0;
        rx_multiframe_sync = 1'b0;
    end
    // ----------------------------------------
    // Alternate mark check
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ami_fault <= 1'b0;
            marked <= 1'b0;
            last_pol <= 1'b0;
        end else if (line_tx_positive || line_tx_negative) begin
            if (marked && last_pol == line_tx_positive) ami_fault <= 1'b1;
            marked <= 1'b1;
            last_pol <= line_tx_positive;
        end
    end
    // One-cycle framing bit report, as the receive framer would give
    task automatic send_fbit(input logic [4:0] fr, input logic rcv,
        input logic exp);
        @(negedge core_clk);
        rx_fbit <= '{1'b1, 1'b1, fr, rcv, exp};
        @(negedge core_clk);
        rx_fbit <= '0;
    endtask
    task automatic sync_pulse();
        @(negedge core_clk);
        rx_multiframe_sync <= 1'b1;
        @(negedge core_clk);
        rx_multiframe_sync <= 1'b0;
    endtask
endmodule // tfa_line_model

//--- tfa_pkg.sv
/*
 Types of the T1 framing, alarm and data link control block.
 Assumes nothing beyond the constants header.
*/
package tfa_pkg;
    typedef struct packed {
        logic [4:0] frame;
        logic fslot;
        logic [4:0] chan;
        logic [2:0] bitn;
    } tfa_pos_s;
    typedef struct packed {
        logic valid;
        logic is_fs;
        logic [4:0] frame;
        logic received;
        logic expected;
    } tfa_rx_fbit_s;
    typedef struct packed {
        logic esf_mode;
        logic transparent;
        logic hdlc_chan_rate;
    } tfa_mode_s;
    typedef enum logic [3:0] {
        TFA_SRC_NORMAL = 4'b0001,
        TFA_SRC_ONES = 4'b0010,
        TFA_SRC_LUP = 4'b0100,
        TFA_SRC_LDN = 4'b1000
    } tfa_src_e;
endpackage
